// >>> rtl/ffcc_coeff_mem.sv
// ffcc_coeff_mem: simple dual-port memory, one write port, one read port.
// assumes a single clock; read data are registered, one cycle after address.
`timescale 1ns/1ps
`default_nettype none
module ffcc_coeff_mem #(
   parameter int W  = 28,
   parameter int AW = 11
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output var  logic [W-1:0]  rdata
);

   logic [W-1:0] mem [0:(2**AW)-1];

   ////////////////////////////////////////////////////////////////////////////
   // no reset on the array: contents are defined by the owner (coefficient clear pass, accumulator first-line write)
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr]; // read before write on the same address
   end

endmodule : ffcc_coeff_mem
`default_nettype wire

// >>> rtl/ffcc_pkg.sv
// ffcc_pkg: shared constants and types of the flat field correction block.
// assumes a 32-bit register bus with byte addresses and one register per word.
package ffcc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses)
   localparam int         REG_AW           = 8;
   localparam logic [7:0] REG_CTRL         = 8'h00;
   localparam logic [7:0] REG_CMD          = 8'h04;
   localparam logic [7:0] REG_TARGET       = 8'h08;
   localparam logic [7:0] REG_REGION_START = 8'h0c;
   localparam logic [7:0] REG_REGION_SPAN  = 8'h10;
   localparam logic [7:0] REG_STATUS       = 8'h14;

   // control word fields
   localparam int CTRL_MODE_LSB    = 0;
   localparam int CTRL_ALGO_BIT    = 2;
   localparam int CTRL_LINES_BIT   = 3;
   localparam int CTRL_ROW_LSB     = 4;
   localparam int CTRL_SET_LSB     = 6;
   localparam int CTRL_GRAN_BIT    = 9;
   localparam int CTRL_FORMULA_BIT = 10;

   // command bits, status fields
   localparam int CMD_DARK_BIT   = 0;
   localparam int CMD_GAIN_BIT   = 1;
   localparam int CMD_PASS_BIT   = 2;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_PEAK_LSB  = 16;

   // coefficient format: gain is unsigned fixed point with GAIN_FRAC fraction bits
   localparam int          GAIN_W     = 16;
   localparam int          GAIN_FRAC  = 12;
   localparam logic [15:0] GAIN_UNITY = 16'h1000;
   localparam int          SET_W      = 3;

   // values after reset
   localparam logic [31:0] TARGET_RST = 32'h0000_0800;
   localparam logic [31:0] START_RST  = 32'h0000_0000;

   typedef enum logic [1:0] {
      MODE_OFF         = 2'h0,
      MODE_ACTIVE      = 2'h1,
      MODE_CALIBRATION = 2'h2
   } ffcc_mode_t;

   typedef enum logic [1:0] {
      ROW_ALL           = 2'h0,
      ROW_FIRST         = 2'h1,
      SECOND_SENSOR_ROW = 2'h2
   } ffcc_row_t;

   typedef enum logic {
      ALGO_PEAK                = 1'b0,
      GAIN_TO_PROGRAMMED_LEVEL = 1'b1
   } ffcc_algo_t;

   typedef enum logic [8:0] {
      ST_CLEAR = 9'h001,
      ST_IDLE  = 9'h002,
      ST_ACCUM = 9'h004,
      ST_PKRD  = 9'h008,
      ST_PKWT  = 9'h010,
      ST_CRD   = 9'h020,
      ST_CWT   = 9'h040,
      ST_DIV   = 9'h080,
      ST_WR    = 9'h100
   } ffcc_state_t;

   // byte-enable merge of a bus write into an old register view
   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

endpackage : ffcc_pkg

// >>> rtl/ffcc_top.sv
// ffcc_top: per-column flat field correction with its calibration engine.
// assumes the pixel stream comes from logic on clk, no back-pressure downstream.
`timescale 1ns/1ps
`default_nettype none
module ffcc_top
   import ffcc_pkg::*;
#(
   parameter int PIX_W      = 12,
   parameter int COLS       = 2048,
   parameter int NSETS      = 5,
   parameter int LOG2_SHORT = 11,
   parameter int LOG2_LONG  = 12
) (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic [ffcc_pkg::REG_AW-1:0] avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output var  logic [31:0]             avs_readdata,
   output var  logic                    avs_waitrequest,
   input  wire logic                    pixInValid,
   input  wire logic                    pixInSol,
   input  wire logic                    pixInRow,
   input  wire logic [PIX_W-1:0]        pixInData,
   output var  logic                    pixOutValid,
   output var  logic                    pixOutSol,
   output var  logic [PIX_W-1:0]        pixOutData,
   output var  logic                    calBusy
);
   import ffcc_pkg::*;

   localparam int COL_W = $clog2(COLS);
   localparam int CA_W  = SET_W + COL_W;
   localparam int ACC_W = PIX_W + LOG2_LONG;
   localparam int CO_W  = PIX_W + GAIN_W;
   localparam int DV_W  = PIX_W + GAIN_FRAC;
   localparam int LD_W  = LOG2_LONG + 1;
   localparam int DC_W  = $clog2(DV_W + 1);

   if ((2**COL_W != COLS) || COLS < 2 || NSETS < 1 || NSETS > 2**SET_W || PIX_W > 16
       || LOG2_SHORT < 1 || LOG2_LONG < LOG2_SHORT) begin : g_bad_params
      $error("ffcc_top: unsupported parameter values");
   end

   typedef struct packed {
      ffcc_state_t      st;
      ffcc_mode_t       mode;
      ffcc_algo_t       algo;
      logic             lineLong;
      ffcc_row_t        rowSel;
      logic [SET_W-1:0] setSel;
      logic [PIX_W-1:0] target;
      logic [COL_W-1:0] regStart;
      logic [COL_W:0]   regSpan;
      logic             gainCal;
      logic [COL_W-1:0] colCnt;
      logic [LD_W-1:0]  linesDone;
      logic             lineActive, lineFirst;
      logic             p1Valid, p1Sol, p1Acc, p1First;
      logic [PIX_W-1:0] p1Data;
      logic [COL_W-1:0] p1Col;
      logic             outValid, outSol, busy;
      logic [PIX_W-1:0] outData;
      logic             waitReq;
      logic [31:0]      rdData;
      logic [COL_W:0]   calCol;
      logic [CA_W-1:0]  clrAddr;
      logic [PIX_W-1:0] peak, curOff, sig, rem;
      logic [DV_W-1:0]  quot;
      logic [DC_W-1:0]  divCnt;
   } ffcc_regs_t;

   ffcc_regs_t r_ff, nxt_r;

   logic [CA_W-1:0]   coeffRaddr;
   logic [CO_W-1:0]   coeffRd, coeffWdata;
   logic              coeffWe, accWe, engineOwns, rowOk, wrTake, corrOn;
   logic [COL_W-1:0]  accRaddr, inCol;
   logic [ACC_W-1:0]  accRd, accWdata;
   logic [PIX_W-1:0]  coeffOff, avgNow, sigNow, level;
   logic [GAIN_W-1:0] coeffGain;
   logic [COL_W:0]    regEnd;
   logic [COL_W+1:0]  endSum;
   logic [4:0]        sh;
   logic [LD_W-1:0]   lineGoal;

   // offset minus first, clamp at zero, then gain and clamp at full scale
   function automatic logic [PIX_W-1:0] correct_pix(input logic [PIX_W-1:0]  pix,
                                                    input logic [PIX_W-1:0]  off,
                                                    input logic [GAIN_W-1:0] gain);
      logic [PIX_W+GAIN_W-1:0] prod;
      logic [PIX_W+GAIN_W-1:0] scaled;
      prod   = (pix > off) ? (PIX_W+GAIN_W)'(pix - off) * (PIX_W+GAIN_W)'(gain) : '0;
      scaled = prod >> GAIN_FRAC;
      return (scaled > (PIX_W+GAIN_W)'({PIX_W{1'b1}})) ? {PIX_W{1'b1}} : PIX_W'(scaled);
   endfunction : correct_pix

   function automatic logic in_roi(input logic [COL_W-1:0] col, input logic [COL_W-1:0] start,
                                   input logic [COL_W:0] stop);
      return ({1'b0, col} >= {1'b0, start}) && ({1'b0, col} < stop);
   endfunction : in_roi

   ////////////////////////////////////////////////////////////////////////////
   // shared decode and memory addressing
   assign endSum     = (COL_W+2)'(r_ff.regStart) + (COL_W+2)'(r_ff.regSpan);
   assign regEnd     = (endSum > (COL_W+2)'(COLS)) ? (COL_W+1)'(COLS) : (COL_W+1)'(endSum);
   assign sh         = r_ff.lineLong ? 5'(LOG2_LONG) : 5'(LOG2_SHORT);
   assign lineGoal   = LD_W'(1) << sh;
   assign rowOk      = (r_ff.rowSel == ROW_ALL) || (r_ff.rowSel == ROW_FIRST && !pixInRow)
                       || (r_ff.rowSel == SECOND_SENSOR_ROW && pixInRow);
   assign inCol      = pixInSol ? '0 : r_ff.colCnt;
   assign engineOwns = (r_ff.st == ST_PKRD) || (r_ff.st == ST_CRD);
   assign coeffRaddr = {r_ff.setSel, engineOwns ? r_ff.calCol[COL_W-1:0] : inCol};
   assign accRaddr   = engineOwns ? r_ff.calCol[COL_W-1:0] : inCol;
   assign coeffOff   = coeffRd[CO_W-1 -: PIX_W];
   assign coeffGain  = coeffRd[GAIN_W-1:0];
   assign avgNow     = PIX_W'(accRd >> sh);
   assign sigNow     = (avgNow > coeffOff) ? PIX_W'(avgNow - coeffOff) : PIX_W'(1); // never divide by 0
   assign level      = (r_ff.algo == GAIN_TO_PROGRAMMED_LEVEL) ? r_ff.target : r_ff.peak;
   assign corrOn     = (r_ff.mode == MODE_ACTIVE) && (r_ff.st != ST_CLEAR);
   assign wrTake     = avs_write && !r_ff.waitReq;
   assign accWe      = r_ff.p1Acc;
   assign accWdata   = r_ff.p1First ? ACC_W'(r_ff.p1Data) : ACC_W'(accRd + ACC_W'(r_ff.p1Data));

   // the clear pass owns the write port; otherwise the engine writes its current column
   ffcc_coeff_mem #(.W(CO_W), .AW(CA_W)) u_coeff (
      .clk(clk), .we(coeffWe), .waddr((r_ff.st == ST_CLEAR) ? r_ff.clrAddr
         : {r_ff.setSel, r_ff.calCol[COL_W-1:0]}),
      .wdata(coeffWdata), .raddr(coeffRaddr), .rdata(coeffRd));

   ffcc_coeff_mem #(.W(ACC_W), .AW(COL_W)) u_accum (
      .clk(clk), .we(accWe), .waddr(r_ff.p1Col), .wdata(accWdata), .raddr(accRaddr), .rdata(accRd));

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic: bus slave, pixel pipeline, calibration engine
   always_comb begin
      logic [31:0]    ctrlView, merged;
      logic           lineAct, lineFst, lastCol;
      logic [PIX_W:0] rem2;
      ctrlView = '0;
      merged   = '0;
      lineAct  = r_ff.lineActive;
      lineFst  = r_ff.lineFirst;
      lastCol  = (r_ff.calCol + (COL_W+1)'(1)) >= regEnd;
      rem2     = {r_ff.rem, r_ff.quot[DV_W-1]};
      nxt_r    = r_ff;
      coeffWe  = 1'b0;
      coeffWdata = '0;
      ctrlView[CTRL_MODE_LSB +: 2]     = r_ff.mode;
      ctrlView[CTRL_ALGO_BIT]          = r_ff.algo;
      ctrlView[CTRL_LINES_BIT]         = r_ff.lineLong;
      ctrlView[CTRL_ROW_LSB +: 2]      = r_ff.rowSel;
      ctrlView[CTRL_SET_LSB +: SET_W]  = r_ff.setSel;
      ctrlView[CTRL_GRAN_BIT]          = 1'b1;
      // bus answer: waitrequest drops one cycle after a request is seen
      nxt_r.waitReq = !((avs_read || avs_write) && r_ff.waitReq);
      if (avs_read && r_ff.waitReq) begin
         case (avs_address & 8'hfc)
            REG_CTRL:         nxt_r.rdData = ctrlView;
            REG_TARGET:       nxt_r.rdData = 32'(r_ff.target);
            REG_REGION_START: nxt_r.rdData = 32'(r_ff.regStart);
            REG_REGION_SPAN:  nxt_r.rdData = 32'(r_ff.regSpan);
            REG_STATUS:       nxt_r.rdData = (32'(r_ff.peak) << STAT_PEAK_LSB) | 32'(r_ff.busy);
            default:          nxt_r.rdData = '0;
         endcase
      end
      if (wrTake) begin
         case (avs_address & 8'hfc)
            REG_CTRL: begin
               merged        = merge_bytes(ctrlView, avs_writedata, avs_byteenable);
               nxt_r.mode    = ffcc_mode_t'(merged[CTRL_MODE_LSB +: 2]);
               nxt_r.algo    = ffcc_algo_t'(merged[CTRL_ALGO_BIT]);
               nxt_r.lineLong = merged[CTRL_LINES_BIT];
               nxt_r.rowSel  = ffcc_row_t'(merged[CTRL_ROW_LSB +: 2]);
               if ({1'b0, merged[CTRL_SET_LSB +: SET_W]} < (SET_W+1)'(NSETS)) begin
                  nxt_r.setSel = merged[CTRL_SET_LSB +: SET_W];
               end
            end
            REG_TARGET: begin
               nxt_r.target = PIX_W'(merge_bytes(32'(r_ff.target), avs_writedata, avs_byteenable));
            end
            REG_REGION_START: nxt_r.regStart = COL_W'(merge_bytes(32'(r_ff.regStart), avs_writedata, avs_byteenable));
            REG_REGION_SPAN: begin
               nxt_r.regSpan = (COL_W+1)'(merge_bytes(32'(r_ff.regSpan), avs_writedata, avs_byteenable));
            end
            REG_CMD: begin
               if (r_ff.st == ST_IDLE && avs_byteenable[0]) begin
                  if (avs_writedata[CMD_PASS_BIT]) begin
                     nxt_r.st      = ST_CLEAR;
                     nxt_r.clrAddr = '0;
                  end else if (r_ff.mode == MODE_CALIBRATION
                               && (avs_writedata[CMD_DARK_BIT] || avs_writedata[CMD_GAIN_BIT])) begin
                     nxt_r.st         = ST_ACCUM;
                     nxt_r.gainCal    = !avs_writedata[CMD_DARK_BIT];
                     nxt_r.linesDone  = '0;
                     nxt_r.lineActive = 1'b0;
                  end
               end
            end
            default: ;
         endcase
      end
      // pixel pipeline: column count, stage 1 (coefficient read), output
      if (pixInValid) begin
         nxt_r.colCnt = COL_W'(inCol + COL_W'(1));
         if (pixInSol && r_ff.st == ST_ACCUM) begin
            lineAct = rowOk && (r_ff.linesDone < lineGoal);
            lineFst = (r_ff.linesDone == '0);
            nxt_r.linesDone = LD_W'(r_ff.linesDone + LD_W'(lineAct));
            if (rowOk && r_ff.linesDone == lineGoal) begin
               lineAct      = 1'b0;
               nxt_r.calCol = (COL_W+1)'(r_ff.regStart);
               nxt_r.peak   = '0;
               if ({1'b0, r_ff.regStart} >= regEnd) begin
                  nxt_r.st = ST_IDLE;
               end else begin
                  nxt_r.st = (r_ff.gainCal && r_ff.algo == ALGO_PEAK) ? ST_PKRD : ST_CRD;
               end
            end
            nxt_r.lineActive = lineAct;
            nxt_r.lineFirst  = lineFst;
         end
      end
      nxt_r.p1Valid  = pixInValid;
      nxt_r.p1Sol    = pixInSol;
      nxt_r.p1Data   = pixInData;
      nxt_r.p1Col    = inCol;
      nxt_r.p1First  = lineFst;
      nxt_r.p1Acc    = pixInValid && r_ff.st == ST_ACCUM && lineAct
                       && in_roi(inCol, r_ff.regStart, regEnd);
      nxt_r.outValid = r_ff.p1Valid;
      nxt_r.outSol   = r_ff.p1Sol;
      nxt_r.outData  = corrOn ? correct_pix(r_ff.p1Data, coeffOff, coeffGain) : r_ff.p1Data;
      // calibration engine, one column at a time
      case (r_ff.st)
         ST_CLEAR: begin
            coeffWe       = 1'b1;
            coeffWdata    = {PIX_W'(0), GAIN_UNITY};
            nxt_r.clrAddr = CA_W'(r_ff.clrAddr + CA_W'(1));
            if (r_ff.clrAddr == {CA_W{1'b1}}) begin
               nxt_r.st = ST_IDLE;
            end
         end
         ST_PKRD: nxt_r.st = ST_PKWT;
         ST_PKWT: begin
            if (sigNow > r_ff.peak) begin
               nxt_r.peak = sigNow;
            end
            nxt_r.calCol = lastCol ? (COL_W+1)'(r_ff.regStart) : (COL_W+1)'(r_ff.calCol + 1'b1);
            nxt_r.st     = lastCol ? ST_CRD : ST_PKRD;
         end
         ST_CRD: nxt_r.st = ST_CWT;
         ST_CWT: begin
            if (!r_ff.gainCal) begin
               coeffWe      = 1'b1;
               coeffWdata   = {avgNow, coeffGain};
               nxt_r.calCol = (COL_W+1)'(r_ff.calCol + 1'b1);
               nxt_r.st     = lastCol ? ST_IDLE : ST_CRD;
            end else begin
               nxt_r.curOff = coeffOff;
               nxt_r.sig    = sigNow;
               nxt_r.rem    = '0;
               nxt_r.quot   = DV_W'(level) << GAIN_FRAC;
               nxt_r.divCnt = '0;
               nxt_r.st     = ST_DIV;
            end
         end
         ST_DIV: begin
            // restoring divide, one quotient bit per cycle: slow but small
            nxt_r.rem  = (rem2 >= {1'b0, r_ff.sig}) ? PIX_W'(rem2 - {1'b0, r_ff.sig}) : PIX_W'(rem2);
            nxt_r.quot = {r_ff.quot[DV_W-2:0], rem2 >= {1'b0, r_ff.sig}};
            nxt_r.divCnt = DC_W'(r_ff.divCnt + 1'b1);
            if (r_ff.divCnt == DC_W'(DV_W - 1)) begin
               nxt_r.st = ST_WR;
            end
         end
         ST_WR: begin
            coeffWe      = 1'b1;
            coeffWdata   = {r_ff.curOff, (r_ff.quot > DV_W'({GAIN_W{1'b1}})) ? {GAIN_W{1'b1}}
                                                                            : GAIN_W'(r_ff.quot)};
            nxt_r.calCol = (COL_W+1)'(r_ff.calCol + 1'b1);
            nxt_r.st     = lastCol ? ST_IDLE : ST_CRD;
         end
         default: ;
      endcase
      nxt_r.busy = (nxt_r.st != ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; coefficients are cleared to neutral after every reset
   always_ff @(posedge clk) begin
      if (srst) begin
         r_ff          <= '0;
         r_ff.st       <= ST_CLEAR;
         r_ff.busy     <= 1'b1;
         r_ff.waitReq  <= 1'b1;
         r_ff.target   <= PIX_W'(TARGET_RST);
         r_ff.regStart <= COL_W'(START_RST);
         r_ff.regSpan  <= (COL_W+1)'(COLS);
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign avs_readdata    = r_ff.rdData;
   assign avs_waitrequest = r_ff.waitReq;
   assign pixOutValid     = r_ff.outValid;
   assign pixOutSol       = r_ff.outSol;
   assign pixOutData      = r_ff.outData;
   assign calBusy         = r_ff.busy;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_col_restart; pixInValid && pixInSol |=> r_ff.p1Col == '0 && r_ff.colCnt == COL_W'(1); endproperty
   a_col_restart: assert property (p_col_restart) else $error("column count not restarted");
   property p_correct;
      r_ff.outValid && $past(corrOn) |-> r_ff.outData == correct_pix($past(pixInData, 2), $past(coeffOff),
                                                                    $past(coeffGain));
   endproperty
   a_correct: assert property (p_correct) else $error("corrected pixel wrong");
   property p_sat_zero;
      $past(r_ff.p1Valid) && $past(corrOn) && $past(r_ff.p1Data) <= $past(coeffOff) |-> r_ff.outData == '0;
   endproperty
   a_sat_zero: assert property (p_sat_zero) else $error("negative difference not clamped");
   property p_off_pass; r_ff.outValid && !$past(corrOn) |-> r_ff.outData == $past(pixInData, 2); endproperty
   a_off_pass: assert property (p_off_pass) else $error("uncorrected pixel altered");
   property p_set_addr; pixInValid && !engineOwns |-> coeffRaddr[CA_W-1 -: SET_W] == r_ff.setSel; endproperty
   a_set_addr: assert property (p_set_addr) else $error("wrong coefficient set");
   property p_lines; (r_ff.st == ST_ACCUM ##1 r_ff.st != ST_ACCUM) |-> $past(r_ff.linesDone) == $past(lineGoal);
   endproperty
   a_lines: assert property (p_lines) else $error("accumulation ended early");
   property p_row; r_ff.st == ST_ACCUM && pixInValid && pixInSol && !rowOk |=> $stable(r_ff.linesDone); endproperty
   a_row: assert property (p_row) else $error("unselected row counted");
   property p_roi; accWe |-> in_roi(r_ff.p1Col, r_ff.regStart, regEnd); endproperty
   a_roi: assert property (p_roi) else $error("accumulate outside region");
   property p_dark; coeffWe && r_ff.st == ST_CWT |-> coeffWdata[CO_W-1 -: PIX_W] == PIX_W'(accRd >> sh); endproperty
   a_dark: assert property (p_dark) else $error("dark offset not the line average");
   property p_clear; r_ff.st == ST_CLEAR |-> coeffWe && coeffWdata == {PIX_W'(0), GAIN_UNITY}; endproperty
   a_clear: assert property (p_clear) else $error("clear value not neutral");
   property p_target;
      wrTake && (avs_address & 8'hfc) == REG_TARGET && avs_byteenable == 4'hf
         |=> r_ff.target == PIX_W'($past(avs_writedata));
   endproperty
   a_target: assert property (p_target) else $error("target level not stored");
   property p_div_level;
      r_ff.st == ST_WR |-> (2*DV_W)'(r_ff.quot) * (2*DV_W)'(r_ff.sig) <= (2*DV_W)'(level) << GAIN_FRAC
         && (2*DV_W)'(r_ff.quot + 1'b1) * (2*DV_W)'(r_ff.sig) > (2*DV_W)'(level) << GAIN_FRAC;
   endproperty
   a_div_level: assert property (p_div_level) else $error("gain does not reach level");
   c_clear_done: cover property (r_ff.st == ST_CLEAR ##1 r_ff.st == ST_IDLE);
   c_accum_done: cover property (r_ff.st == ST_ACCUM ##1 r_ff.st == ST_PKRD);
   c_gain_write: cover property (r_ff.st == ST_WR && r_ff.algo == GAIN_TO_PROGRAMMED_LEVEL);

endmodule : ffcc_top
`default_nettype wire

// >>> verif/ffcc_sensor_model.sv
// ffcc_sensor_model: line source standing in for the sensor readout.
// assumes send is called just after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module ffcc_sensor_model #(
   parameter int N = 8
) (
   input  wire logic        clk,
   output var  logic        vld,
   output var  logic        sol,
   output var  logic        row,
   output var  logic [11:0] dat
);
   initial begin
      {vld, sol, row} = '0;
      dat = '0;
   end
   // column c carries v+c*s; idle data is inverted so a stale pixel never looks valid
   task automatic send(input logic [11:0] v, s, input logic r);
      for (int c = 0; c < N; c++) begin
         @(posedge clk);
         vld <= 1'b1;
         sol <= (c == 0);
         row <= r;
         dat <= v + 12'(c) * s;
      end
      @(posedge clk);
      vld <= 1'b0;
      dat <= ~dat;
   endtask : send
endmodule : ffcc_sensor_model
`default_nettype wire

// >>> verif/tb_top.sv
// tb_top: drives ffcc_top over its register bus and a line source.
// assumes COLS=8 and 2 or 4 line sums so calibration runs stay short.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ffcc_pkg::*;
   localparam int N = 8;
   logic clk = 0, srst = 1, rd = 0, wr = 0, am = 0, mon = 0, ov, os, busy, wq, iv, is, ir;
   logic [7:0] adr = 0;
   logic [31:0] wd = 0, rdat, q;
   logic [11:0] id, od, offA [N];
   logic [15:0] gainA [N];
   logic [12:0] expQ [$];
   int failures = 0, n_checks = 0;
   ffcc_top #(.COLS(N), .LOG2_SHORT(1), .LOG2_LONG(2)) dut (.clk(clk), .srst(srst), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
      .avs_waitrequest(wq), .pixInValid(iv), .pixInSol(is), .pixInRow(ir), .pixInData(id),
      .pixOutValid(ov), .pixOutSol(os), .pixOutData(od), .calBusy(busy));
   ffcc_sensor_model #(.N(N)) src (.clk(clk), .vld(iv), .sol(is), .row(ir), .dat(id));
   initial forever #2.5 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      wrap_up();
   end
   // outputs keep input order, so one queue of expectations is enough
   always @(posedge clk) if (mon && ov === 1'b1) chk(32'({os, od}), 32'(expQ.pop_front()));
   task automatic chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////
   // request held until waitrequest is sampled low; extra edge keeps drops apart
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk); while (wq !== 1'b0);
      r = rdat;
      rd <= 0;
      wr <= 0;
      @(posedge clk);
   endtask : bus
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 0, q);
      chk(q, e);
   endtask : rdc
   task automatic idle;
      while (busy !== 1'b0) @(posedge clk);
   endtask : idle
   // drain the 2-cycle pipe before a mode change
   task automatic act(input logic [31:0] c, input logic a);
      repeat (3) @(posedge clk);
      bus(1, REG_CTRL, c, q);
      am = a;
      mon = 1;
   endtask : act
   function automatic logic [11:0] corr(input logic [11:0] p, o, input logic [15:0] g);
      logic [31:0] m;
      m = ((p > o) ? 32'(p - o) : 0) * g >> 12;
      return (m > 32'hfff) ? 12'hfff : m[11:0];
   endfunction : corr
   task automatic line(input logic [11:0] v, s, input logic r);
      logic [11:0] p;
      for (int c = 0; c < N; c++) begin
         p = v + 12'(c) * s;
         if (mon) expQ.push_back({c == 0, am ? corr(p, offA[c], gainA[c]) : p});
      end
      src.send(v, s, r);
   endtask : line
   // r2 puts a foreign row line before each wanted one; lvl 0 means peak
   task automatic cal(input logic [31:0] ctl, cmd, input logic [11:0] v, s, input int nl, lo, hi,
                      input logic r2, input logic [31:0] lvl);
      logic [31:0] pk, d, g;
      repeat (3) @(posedge clk);
      mon = 0;
      bus(1, REG_CTRL, ctl, q);
      bus(1, REG_CMD, cmd, q);
      for (int i = 0; i <= nl; i++) begin
         if (r2) src.send(12'hfff, 0, 0);
         src.send(v, s, r2);
      end
      idle();
      pk = lvl;
      for (int c = lo; c < hi; c++) begin
         d = 32'(v + 12'(c) * s - offA[c]);
         if (lvl == 0 && d > pk) pk = d;
      end
      for (int c = lo; c < hi; c++) begin
         d = 32'(v + 12'(c) * s - offA[c]);
         g = (pk << 12) / ((d > 0) ? d : 1);
         if (!cmd[1]) offA[c] = v + 12'(c) * s;
         else gainA[c] = (g > 32'hffff) ? 16'hffff : g[15:0];
      end
   endtask : cal
   initial begin
      offA = '{default: 12'h0};
      gainA = '{default: 16'h1000};
      repeat (16) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      rdc(REG_TARGET, 32'h800);
      rdc(REG_REGION_SPAN, N);
      rdc(REG_CTRL, 32'h200);
      rdc(8'h3c, 0);
      idle();
      act(0, 0);
      line(12'h123, 12'h11, 0);
      cal(32'h52, 1, 12'h100, 12'h10, 2, 0, N, 0, 0);
      bus(1, REG_TARGET, 32'h400, q);
      cal(32'h6e, 2, 12'h300, 12'h18, 4, 0, N, 1, 32'h400);
      act(32'h41, 1);
      line(12'h300, 12'h18, 0);
      line(12'h0f0, 0, 0);
      line(12'hf00, 12'h10, 0);
      bus(1, REG_REGION_START, 2, q);
      bus(1, REG_REGION_SPAN, 4, q);
      cal(32'h42, 2, 12'h200, 12'h30, 2, 2, 6, 0, 0);
      rdc(REG_STATUS, 32'h01a0_0000);
      act(32'h41, 1);
      line(12'h200, 12'h30, 0);
      act(32'h01, 0);
      line(12'h200, 12'h30, 0);
      bus(1, REG_CMD, 4, q);
      chk(32'(busy), 1);
      idle();
      act(32'h41, 0);
      line(12'h200, 12'h30, 0);
      repeat (4) @(posedge clk);
      chk(expQ.size(), 0);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
